/* include/scur_map.svh */
// register offsets, field positions, reset values and counts of the serial channel
`ifndef SCUR_MAP_SVH
`define SCUR_MAP_SVH

`define SCUR_ADDR_MODE      8'h00
`define SCUR_ADDR_CTRL0     8'h04
`define SCUR_ADDR_CTRL1     8'h08
`define SCUR_ADDR_TXBUF     8'h0C
`define SCUR_ADDR_RXBUF     8'h10
`define SCUR_ADDR_SMC4      8'h14
`define SCUR_ADDR_INT_STAT  8'h18
`define SCUR_ADDR_INT_CLR   8'h1C
`define SCUR_ADDR_INT_EN    8'h20
`define SCUR_ADDR_SMC3      8'h24
`define SCUR_ADDR_BAUD      8'h28

`define SCUR_MODE_OFF       3'h0
`define SCUR_MODE_SYNC      3'h1
`define SCUR_MODE_I2C       3'h2
`define SCUR_MODE_UART      3'h4
`define SCUR_MODE_SIM       3'h5

`define SCUR_C0_POL         0
`define SCUR_C0_CTS_SEL     1
`define SCUR_C0_RTS_SEL     2
`define SCUR_C0_CLK_INT     3
`define SCUR_C1_TE          0
`define SCUR_C1_TI          1
`define SCUR_C1_RE          2
`define SCUR_C1_RI          3
`define SCUR_C1_IRS         4
`define SCUR_C1_ERE         5
`define SCUR_RX_OER         12
`define SCUR_S4_STA         0
`define SCUR_S4_RSTA        1
`define SCUR_S4_STP         2
`define SCUR_S4_STSP        3
`define SCUR_INT_RX         0
`define SCUR_INT_TX         1
`define SCUR_S3_CLOCK_OPEN_DRAIN        0

`define SCUR_BAUD_RST       8'h04
`define SCUR_LAST_BIT       3'h7
`define SCUR_SYNC_BITS      3

`endif

/* include/scur_pkg.sv */
// types of the serial channel
package scur_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_SHIFT = 2'b10
	} scur_state_t;
endpackage : scur_pkg

/* hdl/scur_sync.sv */
// two-flop synchronisers for the pin inputs of the serial channel
`timescale 1ns/100ps
`include "scur_map.svh"
module scur_sync (
	input  wire logic                        CLK_IN,
	input  wire logic                        RESET_IN,
	input  wire logic [`SCUR_SYNC_BITS-1:0]  ASYNC_IN,
	output logic      [`SCUR_SYNC_BITS-1:0]  SYNC_OUT
);
	logic [`SCUR_SYNC_BITS-1:0] meta_reg;

	genvar i;
	generate
		for (i = 0; i < `SCUR_SYNC_BITS; i++) begin : g_bit
			// inputs idle high so reset to one avoids a false edge after release
			always_ff @(posedge CLK_IN) begin
				if (RESET_IN) begin
					meta_reg[i] <= 1'b1;
					SYNC_OUT[i] <= 1'b1;
				end else begin
					meta_reg[i] <= ASYNC_IN[i];
					SYNC_OUT[i] <= meta_reg[i];
				end
			end
		end
	endgenerate
endmodule : scur_sync

/* hdl/scur_top.sv */
// multi-mode serial channel: shift engine, register port, flow control and interrupt
`timescale 1ns/100ps
`include "scur_map.svh"
module scur_top (
	input  wire logic        CLK_IN,
	input  wire logic        RESET_IN,
	input  wire logic [7:0]  REG_ADDR_IN,
	input  wire logic [31:0] REG_WDATA_IN,
	input  wire logic        REG_WRITE_IN,
	input  wire logic        REG_READ_IN,
	output logic      [31:0] REG_RDATA_OUT,
	input  wire logic        SERIAL_CLOCK_IN,
	output logic             SERIAL_CLOCK_OUT,
	output logic             SERIAL_CLOCK_OE_OUT,
	input  wire logic        SERIAL_DATA_IN,
	output logic             SERIAL_DATA_OUT,
	input  wire logic        CLEAR_TO_SEND_N_IN,
	output logic             REQUEST_TO_SEND_N_OUT,
	output logic             INTERRUPT_OUT
);
	scur_pkg::scur_state_t state_reg;
	scur_pkg::scur_state_t state_next;

	logic [2:0] serial_mode_select_reg;
	logic [3:0] ctrl0_reg;
	logic       transmit_enable_reg;
	logic       rx_enable_reg;
	logic       tx_interrupt_source_select_reg;
	logic       error_signal_output_enable_reg;
	logic       tx_buffer_empty_flag_reg;
	logic       rx_full_flag_reg;
	logic       overrun_flag_reg;
	logic [7:0] transmit_buffer_reg;
	logic [7:0] receive_buffer_reg;
	logic [3:0] smc4_reg;
	logic       clock_open_drain_reg;
	logic [7:0] baud_reg;
	logic [1:0] int_stat_reg;
	logic [1:0] int_en_reg;
	logic [7:0] div_cnt_reg;
	logic       sclk_int_reg;
	logic       sclk_prev_reg;
	logic [7:0] tx_shift_reg;
	logic [7:0] rx_shift_reg;
	logic [2:0] bit_cnt_reg;
	logic       sdo_reg;
	logic       rts_n_reg;
	logic       sim_arm_reg;
	logic [31:0] rdata_next;

	logic [2:0] pins_sync;
	logic       sclk_sync;
	logic       rxd_sync;
	logic       cts_n_sync;

	scur_sync u_sync (
		.CLK_IN   (CLK_IN),
		.RESET_IN (RESET_IN),
		.ASYNC_IN ({CLEAR_TO_SEND_N_IN, SERIAL_DATA_IN, SERIAL_CLOCK_IN}),
		.SYNC_OUT (pins_sync)
	);
	assign sclk_sync  = pins_sync[0];
	assign rxd_sync   = pins_sync[1];
	assign cts_n_sync = pins_sync[2];

	// control decode
	wire pol        = ctrl0_reg[`SCUR_C0_POL];
	wire cts_sel    = ctrl0_reg[`SCUR_C0_CTS_SEL];
	wire rts_sel    = ctrl0_reg[`SCUR_C0_RTS_SEL];
	wire clk_int    = ctrl0_reg[`SCUR_C0_CLK_INT];
	wire chan_on    = serial_mode_select_reg != `SCUR_MODE_OFF;
	wire idle_level = ~pol;
	wire tick       = div_cnt_reg == 8'h00;

	// register port decode
	wire wr_mode  = REG_WRITE_IN && REG_ADDR_IN == `SCUR_ADDR_MODE;
	wire wr_c0    = REG_WRITE_IN && REG_ADDR_IN == `SCUR_ADDR_CTRL0;
	wire wr_c1    = REG_WRITE_IN && REG_ADDR_IN == `SCUR_ADDR_CTRL1;
	wire wr_txbuf = REG_WRITE_IN && REG_ADDR_IN == `SCUR_ADDR_TXBUF;
	wire wr_s4    = REG_WRITE_IN && REG_ADDR_IN == `SCUR_ADDR_SMC4;
	wire wr_clr   = REG_WRITE_IN && REG_ADDR_IN == `SCUR_ADDR_INT_CLR;
	wire wr_en    = REG_WRITE_IN && REG_ADDR_IN == `SCUR_ADDR_INT_EN;
	wire wr_s3    = REG_WRITE_IN && REG_ADDR_IN == `SCUR_ADDR_SMC3;
	wire wr_baud  = REG_WRITE_IN && REG_ADDR_IN == `SCUR_ADDR_BAUD;
	wire rd_rxbuf = REG_READ_IN && REG_ADDR_IN == `SCUR_ADDR_RXBUF;

	// clock edges: internal ones come from the divider, external ones from the synchronised pin
	wire int_edge   = state_reg == scur_pkg::ST_SHIFT && clk_int && tick;
	wire ext_rise   = !clk_int && sclk_sync && !sclk_prev_reg;
	wire ext_fall   = !clk_int && !sclk_sync && sclk_prev_reg;
	wire int_rise   = int_edge && !sclk_int_reg;
	wire int_fall   = int_edge && sclk_int_reg;
	wire edge_rise  = state_reg == scur_pkg::ST_SHIFT && (int_rise || ext_rise);
	wire edge_fall  = state_reg == scur_pkg::ST_SHIFT && (int_fall || ext_fall);
	wire shift_edge = pol ? edge_rise : edge_fall;
	wire samp_edge  = pol ? edge_fall : edge_rise;

	// start: buffer full, transmit on, CTS low if used; external clock must rest at idle
	wire cts_ok   = !cts_sel || !cts_n_sync;
	wire clk_idle = clk_int || sclk_sync == idle_level;
	wire go       = chan_on && transmit_enable_reg && !tx_buffer_empty_flag_reg && cts_ok && clk_idle;
	wire load     = state_reg == scur_pkg::ST_IDLE && go;
	wire done     = samp_edge && bit_cnt_reg == `SCUR_LAST_BIT;
	wire rx_done  = done && rx_enable_reg;
	wire overrun  = rx_done && rx_full_flag_reg;

	// interrupt events
	wire tx_event  = tx_interrupt_source_select_reg ? done : load;
	wire sim_arm   = serial_mode_select_reg == `SCUR_MODE_SIM
		&& tx_interrupt_source_select_reg && error_signal_output_enable_reg;
	wire sim_event = sim_arm && !sim_arm_reg;
	wire [1:0] int_set = {tx_event || sim_event, rx_done && !rx_full_flag_reg};
	wire [1:0] int_clr = wr_clr ? REG_WDATA_IN[1:0] : 2'h0;

	// condition generation in I2C mode, only while the condition output select is set
	wire cond_go = serial_mode_select_reg == `SCUR_MODE_I2C && smc4_reg[`SCUR_S4_STSP]
		&& state_reg == scur_pkg::ST_IDLE && tick && smc4_reg[2:0] != 3'h0;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			scur_pkg::ST_IDLE:  if (load) state_next = scur_pkg::ST_SHIFT;
			scur_pkg::ST_SHIFT: if (done || !chan_on) state_next = scur_pkg::ST_IDLE;
			default:            state_next = scur_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			state_reg <= scur_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// divider free-runs so that I2C conditions also get a half-period timebase
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			div_cnt_reg  <= `SCUR_BAUD_RST;
			sclk_int_reg <= 1'b1;
			sclk_prev_reg <= 1'b1;
		end else begin
			div_cnt_reg   <= tick || load ? baud_reg : div_cnt_reg - 8'h01;
			sclk_prev_reg <= sclk_sync;
			if (state_reg == scur_pkg::ST_IDLE)
				sclk_int_reg <= idle_level;
			else if (int_edge)
				sclk_int_reg <= ~sclk_int_reg;
		end
	end

	// shift engine: the transmit byte goes out even when only receiving
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			tx_shift_reg <= 8'h00;
			rx_shift_reg <= 8'h00;
			bit_cnt_reg  <= 3'h0;
			sdo_reg      <= 1'b1;
		end else if (load) begin
			tx_shift_reg <= transmit_buffer_reg;
			bit_cnt_reg  <= 3'h0;
		end else if (shift_edge) begin
			sdo_reg      <= tx_shift_reg[0];
			tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
		end else if (samp_edge) begin
			rx_shift_reg <= {rxd_sync, rx_shift_reg[7:1]};
			bit_cnt_reg  <= bit_cnt_reg + 3'h1;
		end else if (cond_go) begin
			sdo_reg      <= smc4_reg[`SCUR_S4_STP] && !smc4_reg[`SCUR_S4_STA] && !smc4_reg[`SCUR_S4_RSTA];
		end
	end

	// request-to-send: low while ready, high during a receive, inactive on internal clock
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			rts_n_reg <= 1'b1;
		end else begin
			rts_n_reg <= clk_int || !rts_sel || !rx_enable_reg || state_next == scur_pkg::ST_SHIFT;
		end
	end

	// buffer flags: receive flags set by hardware win over a same-cycle read; a buffer write wins over load
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			tx_buffer_empty_flag_reg <= 1'b1;
			transmit_buffer_reg      <= 8'h00;
			rx_full_flag_reg         <= 1'b0;
			overrun_flag_reg         <= 1'b0;
			receive_buffer_reg       <= 8'h00;
		end else begin
			if (wr_txbuf)
				transmit_buffer_reg <= REG_WDATA_IN[7:0];
			tx_buffer_empty_flag_reg <= !wr_txbuf && (load || tx_buffer_empty_flag_reg);
			if (rx_done)
				receive_buffer_reg <= {rxd_sync, rx_shift_reg[7:1]};
			rx_full_flag_reg <= rx_done || (rx_full_flag_reg && !rd_rxbuf);
			overrun_flag_reg <= overrun || (overrun_flag_reg && !rd_rxbuf);
		end
	end

	// control registers
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			serial_mode_select_reg         <= `SCUR_MODE_OFF;
			ctrl0_reg                      <= 4'h0;
			transmit_enable_reg            <= 1'b0;
			rx_enable_reg                  <= 1'b0;
			tx_interrupt_source_select_reg <= 1'b0;
			error_signal_output_enable_reg <= 1'b0;
			clock_open_drain_reg           <= 1'b0;
			baud_reg                       <= `SCUR_BAUD_RST;
			int_en_reg                     <= 2'h0;
			sim_arm_reg                    <= 1'b0;
		end else begin
			sim_arm_reg <= sim_arm;
			if (wr_mode) serial_mode_select_reg <= REG_WDATA_IN[2:0];
			if (wr_c0)   ctrl0_reg <= REG_WDATA_IN[3:0];
			if (wr_c1) begin
				transmit_enable_reg            <= REG_WDATA_IN[`SCUR_C1_TE];
				rx_enable_reg                  <= REG_WDATA_IN[`SCUR_C1_RE];
				tx_interrupt_source_select_reg <= REG_WDATA_IN[`SCUR_C1_IRS];
				error_signal_output_enable_reg <= REG_WDATA_IN[`SCUR_C1_ERE];
			end
			if (wr_s3)   clock_open_drain_reg <= REG_WDATA_IN[`SCUR_S3_CLOCK_OPEN_DRAIN];
			if (wr_baud) baud_reg <= REG_WDATA_IN[7:0];
			if (wr_en)   int_en_reg <= REG_WDATA_IN[1:0];
		end
	end

	// condition requests clear themselves once the condition is on the data line
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			smc4_reg <= 4'h0;
		end else if (wr_s4) begin
			smc4_reg <= REG_WDATA_IN[3:0];
		end else if (cond_go) begin
			smc4_reg <= {smc4_reg[`SCUR_S4_STSP], 3'h0};
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			int_stat_reg <= 2'h0;
		end else begin
			int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
		end
	end

	// read mux; unmapped and write-only offsets read zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (REG_ADDR_IN)
			`SCUR_ADDR_MODE:     rdata_next[2:0] = serial_mode_select_reg;
			`SCUR_ADDR_CTRL0:    rdata_next[3:0] = ctrl0_reg;
			`SCUR_ADDR_CTRL1:    rdata_next[5:0] = {error_signal_output_enable_reg, tx_interrupt_source_select_reg,
				rx_full_flag_reg, rx_enable_reg, tx_buffer_empty_flag_reg, transmit_enable_reg};
			`SCUR_ADDR_TXBUF:    rdata_next[7:0] = transmit_buffer_reg;
			`SCUR_ADDR_RXBUF:    rdata_next = {19'h0, overrun_flag_reg, 4'h0, receive_buffer_reg};
			`SCUR_ADDR_SMC4:     rdata_next[3:0] = smc4_reg;
			`SCUR_ADDR_INT_STAT: rdata_next[1:0] = int_stat_reg;
			`SCUR_ADDR_INT_EN:   rdata_next[1:0] = int_en_reg;
			`SCUR_ADDR_SMC3:     rdata_next[0] = clock_open_drain_reg;
			`SCUR_ADDR_BAUD:     rdata_next[7:0] = baud_reg;
			default:             rdata_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			REG_RDATA_OUT <= 32'h0000_0000;
		end else begin
			REG_RDATA_OUT <= REG_READ_IN ? rdata_next : 32'h0000_0000;
		end
	end

	// open-drain clock only pulls low; push-pull drives while the internal clock is in use
	assign SERIAL_CLOCK_OUT      = clock_open_drain_reg ? 1'b0 : sclk_int_reg;
	assign SERIAL_CLOCK_OE_OUT   = chan_on && clk_int && (!clock_open_drain_reg || !sclk_int_reg);
	assign SERIAL_DATA_OUT       = sdo_reg;
	assign REQUEST_TO_SEND_N_OUT = rts_n_reg;
	assign INTERRUPT_OUT         = |(int_stat_reg & int_en_reg);

	chk_rts_internal: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		clk_int && $past(clk_int) |-> REQUEST_TO_SEND_N_OUT) else $error("rts active on internal clock");
	chk_rts_busy: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		!clk_int && rts_sel && rx_enable_reg && load ##1 !clk_int |-> REQUEST_TO_SEND_N_OUT)
		else $error("rts low during receive");
	chk_start_gate: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		state_reg == scur_pkg::ST_IDLE ##1 state_reg == scur_pkg::ST_SHIFT
		|-> $past(transmit_enable_reg) && !$past(tx_buffer_empty_flag_reg) && $past(cts_ok) && $past(clk_idle))
		else $error("transfer started without its conditions");
	chk_edge_order: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		$changed(sdo_reg) && state_reg == scur_pkg::ST_SHIFT |-> $past(pol ? edge_rise : edge_fall))
		else $error("data changed on the sampling edge");
	chk_int_clock_start: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		state_reg == scur_pkg::ST_IDLE && clk_int && go |=> state_reg == scur_pkg::ST_SHIFT ##[1:300] $changed(sclk_int_reg))
		else $error("internal shift clock did not start");
	chk_clock_quiet: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		state_reg == scur_pkg::ST_IDLE [*2] |-> sclk_int_reg == $past(idle_level))
		else $error("shift clock without transfer");
	chk_overrun_set: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		rx_done && rx_full_flag_reg |=> overrun_flag_reg && rx_full_flag_reg) else $error("overrun not flagged");
	chk_overrun_quiet: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		overrun && !int_clr[0] |=> int_stat_reg[0] == $past(int_stat_reg[0])) else $error("overrun touched rx pending");
	chk_rx_arrive: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		rx_done && !rx_full_flag_reg |=> rx_full_flag_reg && int_stat_reg[0]) else $error("received byte not flagged");
	chk_sim_request: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		sim_arm && !$past(sim_arm) |=> int_stat_reg[1]) else $error("smart-card tx request missing");
	chk_rx_needs_tx: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
		$rose(rx_full_flag_reg) |-> $past(rx_enable_reg) && $past(state_reg) == scur_pkg::ST_SHIFT)
		else $error("reception outside a transfer");
endmodule : scur_top

/* bench/scur_partner.sv */
// behavioural far-side serial peripheral: clocks, sends and captures one byte a frame
`timescale 1ns/100ps
module scur_partner (
	input  wire logic       pol_in,
	input  wire logic       ext_in,
	input  wire logic       go_in,
	input  wire logic [7:0] byte_in,
	input  wire logic       sck_in,
	input  wire logic       data_in,
	output logic            sck_out,
	output logic            data_out,
	output logic [7:0]      got_out,
	output logic            done_out
);
	logic      clk_raw;
	int        cnt;
	wire logic raw = sck_in ^ pol_in;
	// idle high for polarity 0 and low for polarity 1, so starts always see an idle clock
	assign sck_out  = clk_raw ^ pol_in;
	assign done_out = (cnt == 8);
	initial begin
		clk_raw  = 1'b1;
		data_out = 1'b1;
		got_out  = 8'h00;
		cnt      = 8;
	end
	// the clock stands still outside frames: exactly 16 half periods per byte
	always @(posedge go_in) begin
		cnt = 0;
		if (ext_in) begin
			repeat (16) #62.5 clk_raw = ~clk_raw;
		end
	end
	always @(negedge raw) begin
		if (cnt < 8) begin
			data_out = byte_in[cnt];
		end
	end
	always @(posedge raw) begin
		if (cnt < 8) begin
			got_out = {data_in, got_out[7:1]};
			cnt     = cnt + 1;
			// last bit held past the channel's pin synchroniser, then the released line shows its inverse
			if (cnt == 8) begin
				#40 data_out = ~data_out;
			end
		end
	end
endmodule : scur_partner

/* bench/tb_scur_top.sv */
// self-checking bench of the serial channel with a far-side peripheral model
`timescale 1ns/100ps
`include "scur_map.svh"
module tb_scur_top;
	logic        clk;
	logic        rst;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        sck_o;
	logic        sck_oe;
	logic        sdo;
	logic        cts_n;
	logic        rts_n;
	logic        irq;
	logic        p_pol;
	logic        p_ext;
	logic        p_go;
	logic [7:0]  p_byte;
	logic        p_sck;
	logic        p_data;
	logic [7:0]  p_got;
	logic        p_done;
	logic [31:0] v;
	int          failures;
	int          cmp_count;
	wire logic   sck = sck_oe ? sck_o : p_sck;

	scur_top i_dut (
		.CLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WRITE_IN(wr), .REG_READ_IN(rd), .REG_RDATA_OUT(rdata),
		.SERIAL_CLOCK_IN(sck), .SERIAL_CLOCK_OUT(sck_o), .SERIAL_CLOCK_OE_OUT(sck_oe),
		.SERIAL_DATA_IN(p_data), .SERIAL_DATA_OUT(sdo), .CLEAR_TO_SEND_N_IN(cts_n),
		.REQUEST_TO_SEND_N_OUT(rts_n), .INTERRUPT_OUT(irq)
	);
	scur_partner i_partner (
		.pol_in(p_pol), .ext_in(p_ext), .go_in(p_go), .byte_in(p_byte), .sck_in(sck),
		.data_in(sdo), .sck_out(p_sck), .data_out(p_data), .got_out(p_got), .done_out(p_done)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	// read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : reg_rd

	task automatic p_start;
		@(posedge clk);
		p_go <= 1'b1;
		@(posedge clk);
		p_go <= 1'b0;
	endtask : p_start

	task automatic wait_done;
		int i;
		for (i = 0; i < 600 && p_done !== 1'b1; i++) begin
			@(posedge clk);
		end
		check("frame done", {31'h0, p_done}, 32'h00000001);
		repeat (10) @(posedge clk);
	endtask : wait_done

	task automatic t_reset;
		reg_rd(`SCUR_ADDR_CTRL1);
		check("ctrl1 reset", v, 32'h00000002);
		reg_rd(`SCUR_ADDR_BAUD);
		check("divider reset", v, {24'h0, `SCUR_BAUD_RST});
		reg_wr(8'h3C, 32'hFFFFFFFF);
		reg_rd(8'h3C);
		check("unmapped read", v, 32'h00000000);
		check("pins reset", {28'h0, sdo, rts_n, irq, sck_oe}, 32'h0000000C);
	endtask : t_reset

	task automatic t_internal;
		reg_wr(`SCUR_ADDR_MODE, {29'h0, `SCUR_MODE_SYNC});
		reg_wr(`SCUR_ADDR_CTRL0, 32'h0000000C);
		reg_wr(`SCUR_ADDR_INT_EN, 32'h00000001);
		reg_wr(`SCUR_ADDR_CTRL1, 32'h00000005);
		p_byte = 8'hA5;
		p_start;
		reg_wr(`SCUR_ADDR_TXBUF, 32'h0000003C);
		check("rts internal", {31'h0, rts_n}, 32'h00000001);
		wait_done;
		check("dummy byte out", {24'h0, p_got}, 32'h0000003C);
		reg_rd(`SCUR_ADDR_INT_STAT);
		check("status byte in", v, 32'h00000003);
		check("irq raised", {31'h0, irq}, 32'h00000001);
		reg_rd(`SCUR_ADDR_CTRL1);
		check("rx full", v, 32'h0000000F);
		reg_wr(`SCUR_ADDR_INT_CLR, 32'h00000001);
		reg_rd(`SCUR_ADDR_INT_STAT);
		check("status cleared", v, 32'h00000002);
		check("irq masked", {31'h0, irq}, 32'h00000000);
		// second byte while the first is unread
		p_byte = 8'h5A;
		p_start;
		reg_wr(`SCUR_ADDR_TXBUF, 32'h000000C3);
		wait_done;
		reg_rd(`SCUR_ADDR_INT_STAT);
		check("overrun no irq", v, 32'h00000002);
		reg_rd(`SCUR_ADDR_RXBUF);
		check("overrun flag", {31'h0, v[`SCUR_RX_OER]}, 32'h00000001);
		reg_rd(`SCUR_ADDR_CTRL1);
		check("rx full cleared", v, 32'h00000007);
	endtask : t_internal

	task automatic t_external;
		p_pol = 1'b1;
		p_ext = 1'b1;
		@(posedge clk);
		cts_n <= 1'b1;
		reg_wr(`SCUR_ADDR_CTRL0, 32'h00000007);
		repeat (5) @(posedge clk);
		check("rts ready", {31'h0, rts_n}, 32'h00000000);
		reg_wr(`SCUR_ADDR_TXBUF, 32'h00000096);
		repeat (20) @(posedge clk);
		reg_rd(`SCUR_ADDR_CTRL1);
		check("start held by cts", {31'h0, v[`SCUR_C1_TI]}, 32'h00000000);
		@(posedge clk);
		cts_n <= 1'b0;
		repeat (10) @(posedge clk);
		check("rts busy", {31'h0, rts_n}, 32'h00000001);
		reg_rd(`SCUR_ADDR_CTRL1);
		check("byte loaded", {31'h0, v[`SCUR_C1_TI]}, 32'h00000001);
		p_byte = 8'h69;
		p_start;
		wait_done;
		check("ext byte out", {24'h0, p_got}, 32'h00000096);
		reg_rd(`SCUR_ADDR_RXBUF);
		check("ext byte in", v, 32'h00000069);
		check("rts ready again", {31'h0, rts_n}, 32'h00000000);
	endtask : t_external

	task automatic t_sim;
		reg_wr(`SCUR_ADDR_INT_CLR, 32'h00000003);
		reg_wr(`SCUR_ADDR_INT_EN, 32'h00000002);
		reg_wr(`SCUR_ADDR_MODE, {29'h0, `SCUR_MODE_SIM});
		reg_wr(`SCUR_ADDR_CTRL1, 32'h00000030);
		reg_rd(`SCUR_ADDR_INT_STAT);
		check("sim tx request", v, 32'h00000002);
		check("sim irq", {31'h0, irq}, 32'h00000001);
		reg_wr(`SCUR_ADDR_INT_CLR, 32'h00000002);
		reg_wr(`SCUR_ADDR_INT_STAT, 32'h00000003);
		reg_rd(`SCUR_ADDR_INT_STAT);
		check("sim cleared", v, 32'h00000000);
		check("sim irq low", {31'h0, irq}, 32'h00000000);
	endtask : t_sim

	// condition select cleared and a full clock period waited before every request
	task automatic t_i2c;
		reg_wr(`SCUR_ADDR_MODE, {29'h0, `SCUR_MODE_I2C});
		reg_wr(`SCUR_ADDR_SMC4, 32'h00000000);
		repeat (10) @(posedge clk);
		reg_wr(`SCUR_ADDR_SMC4, 32'h00000009);
		repeat (10) @(posedge clk);
		check("start on data", {31'h0, sdo}, 32'h00000000);
		reg_rd(`SCUR_ADDR_SMC4);
		check("start request cleared", v, 32'h00000008);
		reg_wr(`SCUR_ADDR_SMC4, 32'h00000000);
		repeat (10) @(posedge clk);
		reg_wr(`SCUR_ADDR_SMC4, 32'h0000000C);
		repeat (10) @(posedge clk);
		check("stop on data", {31'h0, sdo}, 32'h00000001);
		reg_rd(`SCUR_ADDR_SMC4);
		check("stop request cleared", v, 32'h00000008);
	endtask : t_i2c

	task automatic t_open_drain;
		reg_wr(`SCUR_ADDR_MODE, {29'h0, `SCUR_MODE_SYNC});
		reg_wr(`SCUR_ADDR_CTRL0, 32'h00000008);
		reg_rd(`SCUR_ADDR_SMC3);
		check("clock push-pull", {30'h0, sck_oe, sck_o}, 32'h00000003);
		reg_wr(`SCUR_ADDR_SMC3, 32'h00000001);
		reg_rd(`SCUR_ADDR_SMC3);
		check("open drain set", v, 32'h00000001);
		check("clock released", {30'h0, sck_oe, sck_o}, 32'h00000000);
		reg_wr(`SCUR_ADDR_SMC3, 32'h00000000);
		reg_rd(`SCUR_ADDR_SMC3);
		check("clock driven again", {30'h0, sck_oe, sck_o}, 32'h00000003);
		reg_wr(`SCUR_ADDR_MODE, 32'h00000000);
		reg_rd(`SCUR_ADDR_SMC3);
		check("open drain cleared", v, 32'h00000000);
		check("clock pin free", {31'h0, sck_oe}, 32'h00000000);
	endtask : t_open_drain

	initial begin
		failures  = 0;
		cmp_count = 0;
		rst    = 1'b1;
		addr   = 8'h00;
		wdata  = 32'h00000000;
		wr     = 1'b0;
		rd     = 1'b0;
		cts_n  = 1'b1;
		p_pol  = 1'b0;
		p_ext  = 1'b0;
		p_go   = 1'b0;
		p_byte = 8'h00;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_internal;
		t_external;
		t_sim;
		t_i2c;
		t_open_drain;
		summarize;
	end

	// the scenarios take well under 2000 cycles
	initial begin
		#200000;
		failures++;
		summarize;
	end
endmodule : tb_scur_top
